/* File: hdl/smr_consts.svh */
// Constants of the switch misc register group: offsets, field positions,
// reset values and counts. Definitions only; included by bare name.
//
// Summary of operation
// - A 32-bit scratch register resets to zero and only stores what software writes.
// - A function-select bit at one routes its pin to the alternate function, at zero to GPIO.
// - In GPIO mode a direction bit at one makes the pin an output, at zero an input.
// - In alternate mode the direction bit is ignored and the alternate function owns the pin.
// - A no-acknowledge flag at bit 25 is set on an unexpected NACK and cleared by writing one.
// - On lost arbitration the SMBus master retries arbitration by itself.
// - After 16 consecutive lost attempts the transaction aborts and bit 26 is set, W1C.
// - A misplaced START or STOP sets bit 27, cleared by writing one.
// - A bad checksum or a missing configuration-done command sets bit 28, cleared by writing one.
// - A load into an unmapped register sets bit 29, cleared by writing one.
// - With ignore-checksum set the checksum always passes; only a missing configuration-done command then sets bit 28.
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses in configuration space)
`define SMR_OFS_SCRATCH 12'h334
`define SMR_OFS_FUNC 12'h338
`define SMR_OFS_DIR 12'h33C
`define SMR_OFS_LEVEL 12'h340
`define SMR_OFS_STATUS 12'h344

// ==========================================================
// Status field positions
`define SMR_BIT_DONE 24
`define SMR_BIT_NACK 25
`define SMR_BIT_ARB 26
`define SMR_BIT_COND 27
`define SMR_BIT_CSUM 28
`define SMR_BIT_UNMAP 29

// ==========================================================
// Reset values and counts
`define SMR_RST_WORD 32'h0000_0000
`define SMR_RST_PINS 16'h0000
`define SMR_PIN_CNT 16
`define SMR_ARB_LIMIT 16

`endif

/* File: hdl/smr_pkg.sv */
// Types of the switch misc register group.
// Assumes the constants header is compiled alongside.
`default_nettype none
package smr_pkg;
   typedef logic [31:0] smr_word_t;
   typedef enum logic [0:0] {
      SMR_ARB_IDLE = 1'b0,
      SMR_ARB_RETRY = 1'b1
   } smr_arb_st_t;
endpackage
`default_nettype wire

/* File: hdl/smr_pin_if.sv */
// Pin control bundle between the register bank and the pin stage.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface smr_pin_if #(parameter int N = 16);
   logic [N-1:0] sel;
   logic [N-1:0] dir;
   logic [N-1:0] drv;
   logic [N-1:0] lvl;
   modport ctl (output sel, output dir, output drv, input lvl);
   modport pad (input sel, input dir, input drv, output lvl);
endinterface
`default_nettype wire

/* File: hdl/smr_pin_ctl.sv */
// Pin stage: input synchroniser and output/enable mux for each pin.
// Assumes alternate-function signals come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module smr_pin_ctl
   import smr_pkg::*;
#(
   parameter int N = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   smr_pin_if.pad pif,
   input wire logic [N-1:0] gpio_in,
   input wire logic [N-1:0] alt_out,
   input wire logic [N-1:0] alt_oe,
   output logic [N-1:0] gpio_out,
   output logic [N-1:0] gpio_oe
);
   // ==========================================================
   // Per-pin logic
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_pin
         logic s1_q, s2_q, o_q, e_q, o_d, e_d;
         always_comb
         begin
            o_d = pif.sel[i] ? alt_out[i] : pif.drv[i];
            e_d = pif.sel[i] ? alt_oe[i] : pif.dir[i];
         end
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               o_q <= 1'b0;
               e_q <= 1'b0;
            end
            else if (ce)
            begin
               s1_q <= gpio_in[i];
               s2_q <= s1_q;
               o_q <= o_d;
               e_q <= e_d;
            end
         end
         // Level seen in every mode, read back by software
         assign pif.lvl[i] = s2_q;
         assign gpio_out[i] = o_q;
         assign gpio_oe[i] = e_q;
      end
   endgenerate
endmodule
`default_nettype wire

/* File: hdl/smr_arb_retry.sv */
// Lost-arbitration tracker of the master SMBus engine.
// Assumes lost/won are one-cycle pulses on clk_sys, never both at once.
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"
module smr_arb_retry
   import smr_pkg::*;
#(
   parameter int LIMIT = `SMR_ARB_LIMIT
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic arb_lost,
   input wire logic arb_won,
   output logic retry_q,
   output logic abort_q
);
   localparam int CW = $clog2(LIMIT);
   smr_arb_st_t st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic retry_d, abort_d;
   logic last;

   // ==========================================================
   // Consecutive-loss counting
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      retry_d = 1'b0;
      abort_d = 1'b0;
      last = (cnt_q == CW'(LIMIT - 1));
      case (st_q)
         SMR_ARB_IDLE:
         begin
            if (arb_lost)
            begin
               st_d = SMR_ARB_RETRY;
               cnt_d = CW'(1);
               retry_d = 1'b1;
            end
         end
         SMR_ARB_RETRY:
         begin
            if (arb_won)
            begin
               st_d = SMR_ARB_IDLE;
               cnt_d = '0;
            end
            else if (arb_lost && last)
            begin
               st_d = SMR_ARB_IDLE;
               cnt_d = '0;
               abort_d = 1'b1;
            end
            else if (arb_lost)
            begin
               cnt_d = cnt_q + CW'(1);
               retry_d = 1'b1;
            end
         end
         default:
         begin
            st_d = SMR_ARB_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_q <= SMR_ARB_IDLE;
         cnt_q <= '0;
         retry_q <= 1'b0;
         abort_q <= 1'b0;
      end
      else if (ce)
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         retry_q <= retry_d;
         abort_q <= abort_d;
      end
   end

   // ==========================================================
   // Checks
   property p_retry_on_loss;
      @(posedge clk_sys) disable iff (rst)
      ce && arb_lost && !last |=> retry_q && !abort_q;
   endproperty
   a_retry_on_loss: assert property (p_retry_on_loss) else $error("no retry after loss");
   property p_abort_at_limit;
      @(posedge clk_sys) disable iff (rst)
      ce && arb_lost && st_q == SMR_ARB_RETRY && last |=> abort_q && !retry_q;
   endproperty
   a_abort_at_limit: assert property (p_abort_at_limit) else $error("no abort at limit");
   c_abort: cover property (@(posedge clk_sys) disable iff (rst) abort_q);
endmodule
`default_nettype wire

/* File: hdl/smr_top.sv */
// Misc register group: scratch, GPIO control and SMBus/EEPROM status.
// Assumes a single-cycle configuration access port and event pulses
// from the SMBus master and EEPROM loader, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"
module smr_top
   import smr_pkg::*;
#(
   parameter int N = `SMR_PIN_CNT,
   parameter int ARB_LIMIT = `SMR_ARB_LIMIT
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   input wire logic [N-1:0] gpio_in,
   input wire logic [N-1:0] alt_out,
   input wire logic [N-1:0] alt_oe,
   output logic [N-1:0] gpio_out,
   output logic [N-1:0] gpio_oe,
   input wire logic ev_no_ack,
   input wire logic ev_bus_cond,
   input wire logic arb_lost,
   input wire logic arb_won,
   output logic smb_rearb,
   output logic smb_abort,
   input wire logic init_load_done,
   input wire logic ev_csum_bad,
   input wire logic ev_cfg_done_missing,
   input wire logic ev_unmapped,
   input wire logic ignore_init_checksum
);
   // ==========================================================
   // Decode helpers
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic smr_word_t be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   smr_pin_if #(.N(N)) pif ();

   smr_word_t scratch_q, scratch_d;
   logic [N-1:0] sel_q, sel_d, dir_q, dir_d, drv_q, drv_d;
   logic done_q, done_d;
   logic nack_q, nack_d, arb_q, arb_d, cond_q, cond_d;
   logic csum_q, csum_d, unmap_q, unmap_d;
   logic ack_d;
   smr_word_t rdata_d;
   smr_word_t m, w1c;
   logic wr, rd, gp_abort, csum_ev;
   logic [N-1:0] gp_out;

   // ==========================================================
   // Sub-blocks
   smr_pin_ctl #(.N(N)) u_pin (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .pif(pif.pad),
      .gpio_in(gpio_in),
      .alt_out(alt_out),
      .alt_oe(alt_oe),
      .gpio_out(gpio_out),
      .gpio_oe(gpio_oe)
   );

   smr_arb_retry #(.LIMIT(ARB_LIMIT)) u_arb (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .arb_lost(arb_lost),
      .arb_won(arb_won),
      .retry_q(smb_rearb),
      .abort_q(gp_abort)
   );

   assign smb_abort = gp_abort;
   assign pif.sel = sel_q;
   assign pif.dir = dir_q;
   assign pif.drv = drv_q;

   // ==========================================================
   // Register write path
   always_comb
   begin
      wr = cfg_req && cfg_we;
      rd = cfg_req && !cfg_we;
      m = wr ? be_mask(cfg_be) : '0;
      gp_out = ~sel_q & dir_q;
      // A one written clears a status flag other than done; an event in the same cycle wins
      w1c = hit(cfg_addr, `SMR_OFS_STATUS) ? (m & cfg_wdata) : '0;
      // Ignored checksum always passes
      csum_ev = (ev_csum_bad && !ignore_init_checksum) || ev_cfg_done_missing;
      scratch_d = scratch_q;
      sel_d = sel_q;
      dir_d = dir_q;
      drv_d = drv_q;
      if (hit(cfg_addr, `SMR_OFS_SCRATCH))
         scratch_d = (scratch_q & ~m) | (cfg_wdata & m);
      if (hit(cfg_addr, `SMR_OFS_FUNC))
         sel_d = (sel_q & ~m[N-1:0]) | (cfg_wdata[N-1:0] & m[N-1:0]);
      if (hit(cfg_addr, `SMR_OFS_DIR))
         dir_d = (dir_q & ~m[N-1:0]) | (cfg_wdata[N-1:0] & m[N-1:0]);
      if (hit(cfg_addr, `SMR_OFS_LEVEL))
         drv_d = (drv_q & ~(m[N-1:0] & gp_out)) | (cfg_wdata[N-1:0] & m[N-1:0] & gp_out);
      done_d = done_q | init_load_done;
      nack_d = (nack_q & ~w1c[`SMR_BIT_NACK]) | ev_no_ack;
      arb_d = (arb_q & ~w1c[`SMR_BIT_ARB]) | gp_abort;
      cond_d = (cond_q & ~w1c[`SMR_BIT_COND]) | ev_bus_cond;
      csum_d = (csum_q & ~w1c[`SMR_BIT_CSUM]) | csum_ev;
      unmap_d = (unmap_q & ~w1c[`SMR_BIT_UNMAP]) | ev_unmapped;
   end

   // ==========================================================
   // Register read path; unmapped offsets read as zero
   always_comb
   begin
      ack_d = cfg_req;
      rdata_d = '0;
      if (rd)
      begin
         case (cfg_addr)
            `SMR_OFS_SCRATCH: rdata_d = scratch_q;
            `SMR_OFS_FUNC: rdata_d[N-1:0] = sel_q;
            `SMR_OFS_DIR: rdata_d[N-1:0] = dir_q;
            `SMR_OFS_LEVEL: rdata_d[N-1:0] = pif.lvl;
            `SMR_OFS_STATUS:
            begin
               rdata_d[`SMR_BIT_DONE] = done_q;
               rdata_d[`SMR_BIT_NACK] = nack_q;
               rdata_d[`SMR_BIT_ARB] = arb_q;
               rdata_d[`SMR_BIT_COND] = cond_q;
               rdata_d[`SMR_BIT_CSUM] = csum_q;
               rdata_d[`SMR_BIT_UNMAP] = unmap_q;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         scratch_q <= `SMR_RST_WORD;
         sel_q <= `SMR_RST_PINS;
         dir_q <= `SMR_RST_PINS;
         drv_q <= `SMR_RST_PINS;
         done_q <= 1'b0;
         nack_q <= 1'b0;
         arb_q <= 1'b0;
         cond_q <= 1'b0;
         csum_q <= 1'b0;
         unmap_q <= 1'b0;
         cfg_ack <= 1'b0;
         cfg_rdata <= `SMR_RST_WORD;
      end
      else if (ce)
      begin
         scratch_q <= scratch_d;
         sel_q <= sel_d;
         dir_q <= dir_d;
         drv_q <= drv_d;
         done_q <= done_d;
         nack_q <= nack_d;
         arb_q <= arb_d;
         cond_q <= cond_d;
         csum_q <= csum_d;
         unmap_q <= unmap_d;
         cfg_ack <= ack_d;
         cfg_rdata <= rdata_d;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_scratch_rt;
      ce && wr && cfg_be == 4'hF && hit(cfg_addr, `SMR_OFS_SCRATCH)
         |=> scratch_q == $past(cfg_wdata);
   endproperty
   a_scratch_rt: assert property (p_scratch_rt) else $error("scratch not stored");

   property p_alt_owns;
      ce |=> (gpio_oe & $past(sel_q)) == ($past(alt_oe) & $past(sel_q));
   endproperty
   a_alt_owns: assert property (p_alt_owns) else $error("alt enable not routed");

   property p_gp_dir;
      ce |=> (gpio_oe & ~$past(sel_q)) == ($past(dir_q) & ~$past(sel_q));
   endproperty
   a_gp_dir: assert property (p_gp_dir) else $error("gpio direction wrong");

   property p_level_rd;
      ce && rd && hit(cfg_addr, `SMR_OFS_LEVEL)
         |=> cfg_ack && cfg_rdata == {{(32 - N){1'b0}}, $past(pif.lvl)};
   endproperty
   a_level_rd: assert property (p_level_rd) else $error("pin level readback wrong");

   property p_drv_mask;
      ce |=> (drv_q & ~$past(gp_out)) == ($past(drv_q) & ~$past(gp_out));
   endproperty
   a_drv_mask: assert property (p_drv_mask) else $error("non-output pin changed");

   property p_done_sticky;
      ce && init_load_done |=> done_q ##1 done_q;
   endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done flag not held");

   property p_nack_set_wins;
      ce && ev_no_ack |=> nack_q;
   endproperty
   a_nack_set_wins: assert property (p_nack_set_wins) else $error("nack event lost");

   property p_nack_clear;
      ce && !ev_no_ack && w1c[`SMR_BIT_NACK] |=> !nack_q;
   endproperty
   a_nack_clear: assert property (p_nack_clear) else $error("nack not cleared");

   property p_arb_flag;
      ce && gp_abort |=> arb_q;
   endproperty
   a_arb_flag: assert property (p_arb_flag) else $error("abort not flagged");

   property p_cond_flag;
      ce && ev_bus_cond |=> cond_q;
   endproperty
   a_cond_flag: assert property (p_cond_flag) else $error("bus condition lost");

   property p_csum_ignore;
      ce && ev_csum_bad && ignore_init_checksum && !ev_cfg_done_missing && !csum_q
         |=> !csum_q;
   endproperty
   a_csum_ignore: assert property (p_csum_ignore) else $error("ignored checksum flagged");

   property p_unmap_flag;
      ce && ev_unmapped |=> unmap_q;
   endproperty
   a_unmap_flag: assert property (p_unmap_flag) else $error("unmapped attempt lost");

   // Each flag clears only on a one written while its own event is quiet
   property p_arb_clear;
      ce && !gp_abort && w1c[`SMR_BIT_ARB] |=> !arb_q;
   endproperty
   a_arb_clear: assert property (p_arb_clear) else $error("arb flag not cleared");

   property p_cond_clear;
      ce && !ev_bus_cond && w1c[`SMR_BIT_COND] |=> !cond_q;
   endproperty
   a_cond_clear: assert property (p_cond_clear) else $error("cond flag not cleared");

   property p_csum_clear;
      ce && !csum_ev && w1c[`SMR_BIT_CSUM] |=> !csum_q;
   endproperty
   a_csum_clear: assert property (p_csum_clear) else $error("csum flag not cleared");

   property p_unmap_clear;
      ce && !ev_unmapped && w1c[`SMR_BIT_UNMAP] |=> !unmap_q;
   endproperty
   a_unmap_clear: assert property (p_unmap_clear) else $error("unmap flag not cleared");

   // Flags have no write-one-to-set path, so only events can raise them
   property p_nack_quiet;
      ce && !ev_no_ack && !nack_q |=> !nack_q;
   endproperty
   a_nack_quiet: assert property (p_nack_quiet) else $error("nack set without event");

   property p_done_ro;
      ce && !init_load_done && !done_q |=> !done_q;
   endproperty
   a_done_ro: assert property (p_done_ro) else $error("done set without load");

   property p_scratch_hold;
      ce && !(wr && hit(cfg_addr, `SMR_OFS_SCRATCH)) |=> scratch_q == $past(scratch_q);
   endproperty
   a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed");

   property p_level_hold;
      ce && !(wr && hit(cfg_addr, `SMR_OFS_LEVEL)) |=> drv_q == $past(drv_q);
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("drive level changed");

   // Scratch is the only register with no reserved bits
   property p_rsv_zero;
      ce && rd && !hit(cfg_addr, `SMR_OFS_SCRATCH) |=> (cfg_rdata & 32'hC0FF_0000) == 32'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

   c_alt_sel: cover property (ce && |sel_q);
   c_w1c: cover property (ce && nack_q && w1c[`SMR_BIT_NACK]);
   c_gp_write: cover property (ce && wr && hit(cfg_addr, `SMR_OFS_LEVEL) && |gp_out);
   c_ce_freeze: cover property (!ce && ev_no_ack);
endmodule
`default_nettype wire

/* File: tb/smr_pad_model.sv */
// Pad side of the pin block: resolves each pin from device and board drivers.
// Assumes a board pull-up on every pin; ext_drive marks pins the board drives.
`timescale 1ns/1ps
`default_nettype none
module smr_pad_model #(
   parameter int N = 16
)(
   input wire logic [N-1:0] gpio_out,
   input wire logic [N-1:0] gpio_oe,
   input wire logic [N-1:0] ext_lvl,
   input wire logic [N-1:0] ext_drive,
   output logic [N-1:0] pad
);
   // ==========================================================
   // Wire resolution
   // Undriven pins float up, never to the last value seen
   always_comb
   begin
      pad = (gpio_oe & gpio_out) | (~gpio_oe & ext_drive & ext_lvl) | (~gpio_oe & ~ext_drive);
   end
endmodule
`default_nettype wire

/* File: tb/test_switch_misc_gpio_smbus_status_regs.sv */
// Self-checking bench of the misc register group.
// Assumes smr_top, the pad model and the package are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_switch_misc_gpio_smbus_status_regs import smr_pkg::*;;
   localparam int N = 16;
   // Short loss limit keeps the abort case quick
   localparam int LIM = 4;
   typedef struct packed {logic [11:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} smr_row_t;
   logic clk_sys;
   logic rst;
   logic ce;
   logic cfg_req;
   logic cfg_we;
   logic cfg_ack;
   logic ign;
   logic arb_lost;
   logic arb_won;
   logic smb_rearb;
   logic smb_abort;
   logic load_done;
   logic [4:0] ev;
   logic [11:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic [31:0] rd;
   logic [N-1:0] gpio_in;
   logic [N-1:0] alt_out;
   logic [N-1:0] alt_oe;
   logic [N-1:0] gpio_out;
   logic [N-1:0] gpio_oe;
   logic [N-1:0] ext_lvl;
   logic [N-1:0] ext_drive;
   int fail_count;
   int check_count;
   int rearb_n;
   int abort_n;
   int bitpos [5] = '{25, 27, 28, 28, 29};
   smr_row_t rows [7] = '{
      '{12'h334, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{12'h334, 4'h3, 32'h1234_5678, 32'hFFFF_5678},
      '{12'h338, 4'hF, 32'hFFFF_FFFF, 32'h0000_FFFF},
      '{12'h338, 4'hF, 32'h0000_0000, 32'h0000_0000},
      '{12'h33C, 4'hF, 32'hFFFF_A5A5, 32'h0000_A5A5},
      '{12'h344, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
      '{12'h348, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

   smr_top #(.N(N), .ARB_LIMIT(LIM)) DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .gpio_in(gpio_in),
      .alt_out(alt_out), .alt_oe(alt_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .ev_no_ack(ev[0]), .ev_bus_cond(ev[1]), .arb_lost(arb_lost), .arb_won(arb_won),
      .smb_rearb(smb_rearb), .smb_abort(smb_abort), .init_load_done(load_done),
      .ev_csum_bad(ev[2]), .ev_cfg_done_missing(ev[3]), .ev_unmapped(ev[4]),
      .ignore_init_checksum(ign));
   smr_pad_model #(.N(N)) pads (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_lvl(ext_lvl),
      .ext_drive(ext_drive), .pad(gpio_in));

   // ==========================================================
   // Clock, pulse counters and hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      if (smb_rearb === 1'b1) rearb_n++;
      if (smb_abort === 1'b1) abort_n++;
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      report_and_stop();
   end

   // ==========================================================
   // Shared tasks
   task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Ack is fixed one edge after the request, so no wait loop is needed
   task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d);
      @(posedge clk_sys);
      cfg_req <= 1'b1;
      cfg_we <= we;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge clk_sys);
      cfg_req <= 1'b0;
      @(negedge clk_sys);
      check32("ack", 32'h1, {31'h0, cfg_ack});
      rd = cfg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 4'hF, 32'h0);
      check32(name, e, rd);
   endtask
   task automatic lose(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         arb_lost <= 1'b1;
      end
      @(posedge clk_sys);
      arb_lost <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic pulse_ev(input int i);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev <= 5'h0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      {rst, ce, cfg_req, cfg_we, ign, arb_lost, arb_won, load_done} = 8'b1100_0000;
      {cfg_addr, cfg_be, cfg_wdata, ev} = '0;
      {alt_out, alt_oe, ext_lvl, ext_drive} = '0;
      {fail_count, check_count, rearb_n, abort_n} = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk("scratch", 12'h334, 32'h0);
      rdchk("func", 12'h338, 32'h0);
      rdchk("dir", 12'h33C, 32'h0);
      rdchk("level", 12'h340, 32'h0000_FFFF);
      rdchk("status", 12'h344, 32'h0);
      foreach (rows[i])
      begin
         acc(1'b1, rows[i].a, rows[i].be, rows[i].d);
         rdchk("row", rows[i].a, rows[i].e);
      end
      // Board drives GPIO inputs low so pulled-up and driven pins differ
      ext_drive <= 16'hFFFF;
      acc(1'b1, 12'h340, 4'hF, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk_sys);
      check32("oe", 32'h0000_A5A5, {16'h0, gpio_oe});
      check32("out", 32'h0000_A5A5, {16'h0, gpio_out});
      rdchk("level", 12'h340, 32'h0000_A5A5);
      acc(1'b1, 12'h33C, 4'hF, 32'h0000_FFFF);
      repeat (2) @(posedge clk_sys);
      check32("oe", 32'h0000_FFFF, {16'h0, gpio_oe});
      check32("out", 32'h0000_A5A5, {16'h0, gpio_out});
      alt_oe <= 16'h000F;
      alt_out <= 16'h0003;
      acc(1'b1, 12'h338, 4'hF, 32'h0000_00FF);
      repeat (3) @(posedge clk_sys);
      check32("oe", 32'h0000_FF0F, {16'h0, gpio_oe});
      check32("out", 32'h0000_A503, {16'h0, gpio_out});
      rdchk("level", 12'h340, 32'h0000_A503);
      for (int i = 0; i < 5; i++)
      begin
         pulse_ev(i);
         rdchk("flag", 12'h344, 32'h1 << bitpos[i]);
         acc(1'b1, 12'h344, 4'hF, 32'hFFFF_FFFF);
         rdchk("cleared", 12'h344, 32'h0);
      end
      ign <= 1'b1;
      pulse_ev(2);
      rdchk("ignored", 12'h344, 32'h0);
      pulse_ev(3);
      rdchk("missing", 12'h344, 32'h1000_0000);
      ign <= 1'b0;
      acc(1'b1, 12'h344, 4'hF, 32'h1000_0000);
      // Event and clear on one edge: the event must win
      @(posedge clk_sys);
      ev[0] <= 1'b1;
      cfg_req <= 1'b1;
      cfg_we <= 1'b1;
      cfg_addr <= 12'h344;
      cfg_wdata <= 32'h0200_0000;
      @(posedge clk_sys);
      ev <= 5'h0;
      cfg_req <= 1'b0;
      rdchk("race", 12'h344, 32'h0200_0000);
      acc(1'b1, 12'h344, 4'h8, 32'h0200_0000);
      @(posedge clk_sys);
      load_done <= 1'b1;
      @(posedge clk_sys);
      load_done <= 1'b0;
      acc(1'b1, 12'h344, 4'hF, 32'hFFFF_FFFF);
      rdchk("done", 12'h344, 32'h0100_0000);
      lose(LIM - 1);
      @(posedge clk_sys);
      arb_won <= 1'b1;
      @(posedge clk_sys);
      arb_won <= 1'b0;
      lose(LIM - 1);
      check32("rearb", 2 * (LIM - 1), rearb_n);
      check32("abort", 32'h0, abort_n);
      lose(LIM);
      check32("rearb", 3 * (LIM - 1), rearb_n);
      check32("abort", 32'h1, abort_n);
      rdchk("arb", 12'h344, 32'h0500_0000);
      acc(1'b1, 12'h344, 4'hF, 32'h0400_0000);
      rdchk("arb", 12'h344, 32'h0100_0000);
      ce <= 1'b0;
      pulse_ev(0);
      ce <= 1'b1;
      rdchk("frozen", 12'h344, 32'h0100_0000);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk("scratch", 12'h334, 32'h0);
      rdchk("status", 12'h344, 32'h0);
      check32("oe", 32'h0000_0000, {16'h0, gpio_oe});
      check32("out", 32'h0000_0000, {16'h0, gpio_out});
      report_and_stop();
   end
endmodule
`default_nettype wire
